// ===== src/cal_rtc_top.sv
// Calendar clock counters with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none

module cal_rtc_top
   import cal_pkg::*;
(
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_SYS_RST,
   input  wire logic              I_OSC_TICK,
   input  wire logic [ADDR_W-1:0] I_S_AXI_AWADDR,
   input  wire logic              I_S_AXI_AWVALID,
   output logic                   O_S_AXI_AWREADY,
   input  wire logic [31:0]       I_S_AXI_WDATA,
   input  wire logic [3:0]        I_S_AXI_WSTRB,
   input  wire logic              I_S_AXI_WVALID,
   output logic                   O_S_AXI_WREADY,
   output logic [1:0]             O_S_AXI_BRESP,
   output logic                   O_S_AXI_BVALID,
   input  wire logic              I_S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] I_S_AXI_ARADDR,
   input  wire logic              I_S_AXI_ARVALID,
   output logic                   O_S_AXI_ARREADY,
   output logic [31:0]            O_S_AXI_RDATA,
   output logic [1:0]             O_S_AXI_RRESP,
   output logic                   O_S_AXI_RVALID,
   input  wire logic              I_S_AXI_RREADY,
   output logic                   O_IRQ,
   output logic                   O_WAKE
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   function automatic cal_reg_t decode(input logic [ADDR_W-1:0] a);
      logic [17:0] w;
      w = a[ADDR_W-1:2];
      decode = REG_NONE;
      if (a[1:0] == 2'b00) begin
         case (w)
            {2'b00, IDX_CTRL}:  decode = REG_CTRL;
            {2'b00, IDX_SEC}:   decode = REG_SEC;
            {2'b00, IDX_MIN}:   decode = REG_MIN;
            {2'b00, IDX_HOUR}:  decode = REG_HOUR;
            {2'b00, IDX_DAY}:   decode = REG_DAY;
            {2'b00, IDX_WDAY}:  decode = REG_WDAY;
            {2'b00, IDX_MON}:   decode = REG_MON;
            {2'b00, IDX_YEAR}:  decode = REG_YEAR;
            {2'b00, IDX_CENT}:  decode = REG_CENT;
            {2'b00, IDX_CALIB}: decode = REG_CALIB;
            {2'b00, IDX_BASE}:  decode = REG_BASE;
            default:            decode = REG_NONE;
         endcase
      end
   endfunction : decode

   // ----------------------------------------------------------------
   // Month length
   // ----------------------------------------------------------------

   function automatic logic [4:0] last_day(
      input logic [3:0] mon,
      input logic [6:0] yr,
      input logic [2:0] cen
   );
      logic leap;
      // Year 00 of a century is a multiple of 100; of 400 when cen is 0 or 4
      leap = (yr[1:0] == 2'b00) && ((yr != 7'h00) || (cen[1:0] == 2'b00));
      case (mon)
         4'h4, 4'h6, 4'h9, 4'hB: last_day = DAYS_30;
         MON_FEB:                last_day = leap ? DAYS_29 : DAYS_28;
         default:                last_day = DAYS_31;
      endcase
   endfunction : last_day

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------

   cal_if tk ();

   logic              aw_full_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic              w_full_q;
   logic [7:0]        w_byte_q;
   logic              w_lane_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;

   logic              run_q;
   logic              upf_q;
   logic              irqf_q;
   logic              ie_q;
   logic [1:0]        sel_q;
   logic [15:0]       calib_q;

   logic [5:0]        sec_q;
   logic [5:0]        min_q;
   logic [4:0]        hour_q;
   logic [4:0]        day_q;
   logic [2:0]        wday_q;
   logic [3:0]        mon_q;
   logic [6:0]        year_q;
   logic [2:0]        cent_q;

   logic              wr_fire;
   logic              wr_en;
   cal_reg_t          wr_sel;
   cal_reg_t          rd_sel;
   logic              ctrl_wr;
   logic              ld_en;
   logic              stop_evt;
   logic [7:0]        ctrl_rd;
   logic [31:0]       rdata_d;

   logic              tick;
   logic              c_sec;
   logic              c_min;
   logic              c_hour;
   logic              c_day;
   logic              c_mon;
   logic              c_year;
   logic              per_evt;

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------

   assign O_S_AXI_AWREADY = !aw_full_q;
   assign O_S_AXI_WREADY  = !w_full_q;
   assign wr_fire         = aw_full_q && w_full_q && !bvalid_q;
   assign wr_sel          = decode(aw_addr_q);
   // Registers sit in byte lane 0; a write without that lane stores nothing
   assign wr_en           = wr_fire && w_lane_q;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (I_S_AXI_AWVALID && !aw_full_q) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= I_S_AXI_AWADDR;
      end else if (wr_fire) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         w_full_q <= 1'b0;
         w_byte_q <= 8'h00;
         w_lane_q <= 1'b0;
      end else if (I_S_AXI_WVALID && !w_full_q) begin
         w_full_q <= 1'b1;
         w_byte_q <= I_S_AXI_WDATA[7:0];
         w_lane_q <= I_S_AXI_WSTRB[0];
      end else if (wr_fire) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (I_S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   assign O_S_AXI_BVALID = bvalid_q;
   assign O_S_AXI_BRESP  = bresp_q;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------

   assign ctrl_wr  = wr_en && (wr_sel == REG_CTRL);
   assign stop_evt = ctrl_wr && run_q && !w_byte_q[CTRL_RUN_BIT];
   // Counter loads are ignored while running
   assign ld_en    = wr_en && !run_q;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         run_q <= 1'b0;
         ie_q  <= 1'b0;
         sel_q <= 2'b00;
      end else if (ctrl_wr) begin
         run_q <= w_byte_q[CTRL_RUN_BIT];
         ie_q  <= w_byte_q[CTRL_IE_BIT];
         sel_q <= w_byte_q[CTRL_SEL_HI:CTRL_SEL_LO];
      end
   end

   // Writing one leaves a flag alone; a set in the clearing cycle wins
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         upf_q <= 1'b0;
      end else begin
         upf_q <= (upf_q & ~(ctrl_wr & ~w_byte_q[CTRL_UPF_BIT])) | tick;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         irqf_q <= 1'b0;
      end else begin
         irqf_q <= (irqf_q & ~(ctrl_wr & ~w_byte_q[CTRL_IRQ_BIT])) | per_evt;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         calib_q <= CALIB_RST;
      end else if (wr_en && (wr_sel == REG_CALIB) && !run_q) begin
         calib_q <= {8'h00, w_byte_q};
      end
   end

   assign O_IRQ  = ie_q & irqf_q;
   assign O_WAKE = ie_q & irqf_q;

   // ----------------------------------------------------------------
   // Seconds tick source
   // ----------------------------------------------------------------

   assign tk.run    = run_q;
   assign tk.period = calib_q;

   cal_tick_gen u_tick (
      .i_clk      (I_CORE_CLK),
      .i_rst      (I_SYS_RST),
      .i_osc_tick (I_OSC_TICK),
      .tk         (tk.gen)
   );

   // No low-power gating here: the chain keeps counting in halt and hold
   assign tick = tk.tick & run_q;

   // ----------------------------------------------------------------
   // Carry chain
   // ----------------------------------------------------------------

   assign c_sec  = tick && (sec_q >= SEC_MAX);
   assign c_min  = c_sec && (min_q >= MIN_MAX);
   assign c_hour = c_min && (hour_q >= HOUR_MAX);
   assign c_day  = c_hour && (day_q >= last_day(mon_q, year_q, cent_q));
   assign c_mon  = c_day && (mon_q >= MON_MAX);
   assign c_year = c_mon && (year_q >= YEAR_MAX);

   always_comb begin
      case (cal_period_t'(sel_q))
         PER_SEC:  per_evt = tick;
         PER_MIN:  per_evt = c_sec;
         PER_HOUR: per_evt = c_min;
         PER_DAY:  per_evt = c_hour;
         default:  per_evt = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Calendar counters
   // ----------------------------------------------------------------

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || stop_evt) begin
         sec_q  <= SEC_RST;
         min_q  <= MIN_RST;
         hour_q <= HOUR_RST;
         day_q  <= DAY_RST;
         wday_q <= WDAY_RST;
         mon_q  <= MON_RST;
         year_q <= YEAR_RST;
         cent_q <= CENT_RST;
      end else if (ld_en) begin
         // Only the implemented low bits are taken
         case (wr_sel)
            REG_SEC:  sec_q  <= w_byte_q[5:0];
            REG_MIN:  min_q  <= w_byte_q[5:0];
            REG_HOUR: hour_q <= w_byte_q[4:0];
            REG_DAY:  day_q  <= w_byte_q[4:0];
            REG_WDAY: wday_q <= w_byte_q[2:0];
            REG_MON:  mon_q  <= w_byte_q[3:0];
            REG_YEAR: year_q <= w_byte_q[6:0];
            REG_CENT: cent_q <= w_byte_q[2:0];
            default:  sec_q  <= sec_q;
         endcase
      end else if (tick) begin
         sec_q <= c_sec ? SEC_RST : sec_q + 6'h01;
         if (c_sec) begin
            min_q <= c_min ? MIN_RST : min_q + 6'h01;
         end
         if (c_min) begin
            hour_q <= c_hour ? HOUR_RST : hour_q + 5'h01;
         end
         if (c_hour) begin
            day_q  <= c_day ? DAY_RST : day_q + 5'h01;
            wday_q <= (wday_q >= WDAY_MAX) ? WDAY_RST : wday_q + 3'h1;
         end
         if (c_day) begin
            mon_q <= c_mon ? MON_RST : mon_q + 4'h1;
         end
         if (c_mon) begin
            year_q <= c_year ? YEAR_RST : year_q + 7'h01;
         end
         if (c_year) begin
            cent_q <= cent_q + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------

   assign rd_sel  = decode(I_S_AXI_ARADDR);
   // Bits 1:0 are not stored, so they always read back as zero
   assign ctrl_rd = {run_q, upf_q, irqf_q, ie_q, sel_q, 2'b00};

   always_comb begin
      case (rd_sel)
         REG_CTRL:  rdata_d = {24'h00_0000, ctrl_rd};
         REG_SEC:   rdata_d = {26'h000_0000, sec_q};
         REG_MIN:   rdata_d = {26'h000_0000, min_q};
         REG_HOUR:  rdata_d = {27'h000_0000, hour_q};
         REG_DAY:   rdata_d = {27'h000_0000, day_q};
         REG_WDAY:  rdata_d = {29'h0000_0000, wday_q};
         REG_MON:   rdata_d = {28'h000_0000, mon_q};
         REG_YEAR:  rdata_d = {25'h000_0000, year_q};
         REG_CENT:  rdata_d = {29'h0000_0000, cent_q};
         REG_CALIB: rdata_d = {16'h0000, calib_q};
         REG_BASE:  rdata_d = {16'h0000, tk.base};
         default:   rdata_d = 32'h0000_0000;
      endcase
   end

   assign O_S_AXI_ARREADY = !rvalid_q;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (I_S_AXI_ARVALID && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdata_d;
         rresp_q  <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (I_S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   assign O_S_AXI_RVALID = rvalid_q;
   assign O_S_AXI_RDATA  = rdata_q;
   assign O_S_AXI_RRESP  = rresp_q;

endmodule : cal_rtc_top

`default_nettype wire

// ===== common/cal_pkg.sv
// Constants, register map and types shared by the calendar clock design
//
// Summary of operation
// - 16-bit base counter counts oscillator clocks
// - Calibration stage makes the one-second tick
// - Seconds count 0 to 59, wrap, carry
// - Minutes count 0 to 59 on seconds carry
// - Hours count 0 to 23 on minutes carry
// - Day counts from 1 to month length
// - Month length 31, 30, 29 or 28
// - Leap: by four, not hundred, except four hundred
// - Weekday counts 0 to 6 per day
// - Month counts 1 to 12, carries to year
// - Year counts 0 to 99, carries to century
// - Century counts 0 (2000) to 7 (2700)
// - Stopping clears the time counters
// - Stopping returns day to one
// - Run bit starts and halts counting
// - Writes load only while stopped; reads live
// - Count-up flag set on change, cleared by zero
// - Interrupt flag set each period; zero clears
// - Period select: second, minute, hour, day
// - Enable and flag raise interrupt and wake
// - Counting continues in halt and hold modes
`default_nettype none

package cal_pkg;

   localparam int          ADDR_W = 20;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CTRL  = 16'h7EF0;
   localparam logic [15:0] IDX_SEC   = 16'h7EF1;
   localparam logic [15:0] IDX_MIN   = 16'h7EF2;
   localparam logic [15:0] IDX_HOUR  = 16'h7EF3;
   localparam logic [15:0] IDX_DAY   = 16'h7EF4;
   localparam logic [15:0] IDX_WDAY  = 16'h7EF5;
   localparam logic [15:0] IDX_MON   = 16'h7EF6;
   localparam logic [15:0] IDX_YEAR  = 16'h7EF7;
   localparam logic [15:0] IDX_CENT  = 16'h7EF8;
   localparam logic [15:0] IDX_CALIB = 16'h7EF9;
   localparam logic [15:0] IDX_BASE  = 16'h7EFA;

   // Control field positions
   localparam int CTRL_RUN_BIT = 7;
   localparam int CTRL_UPF_BIT = 6;
   localparam int CTRL_IRQ_BIT = 5;
   localparam int CTRL_IE_BIT  = 4;
   localparam int CTRL_SEL_HI  = 3;
   localparam int CTRL_SEL_LO  = 2;

   // Reset and initial values
   localparam logic [5:0]  SEC_RST   = 6'h00;
   localparam logic [5:0]  MIN_RST   = 6'h00;
   localparam logic [4:0]  HOUR_RST  = 5'h00;
   localparam logic [4:0]  DAY_RST   = 5'h01;
   localparam logic [2:0]  WDAY_RST  = 3'h0;
   localparam logic [3:0]  MON_RST   = 4'h1;
   localparam logic [6:0]  YEAR_RST  = 7'h00;
   localparam logic [2:0]  CENT_RST  = 3'h0;
   localparam logic [15:0] BASE_RST  = 16'h0000;
   localparam logic [15:0] CALIB_RST = 16'h7FFF;

   // Counter limits
   localparam logic [5:0]  SEC_MAX  = 6'h3B;
   localparam logic [5:0]  MIN_MAX  = 6'h3B;
   localparam logic [4:0]  HOUR_MAX = 5'h17;
   localparam logic [2:0]  WDAY_MAX = 3'h6;
   localparam logic [3:0]  MON_MAX  = 4'hC;
   localparam logic [6:0]  YEAR_MAX = 7'h63;
   localparam logic [3:0]  MON_FEB  = 4'h2;
   localparam logic [4:0]  DAYS_31  = 5'h1F;
   localparam logic [4:0]  DAYS_30  = 5'h1E;
   localparam logic [4:0]  DAYS_29  = 5'h1D;
   localparam logic [4:0]  DAYS_28  = 5'h1C;

   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      PER_SEC,
      PER_MIN,
      PER_HOUR,
      PER_DAY
   } cal_period_t;

   typedef enum logic [3:0] {
      REG_CTRL, REG_SEC, REG_MIN, REG_HOUR, REG_DAY, REG_WDAY,
      REG_MON, REG_YEAR, REG_CENT, REG_CALIB, REG_BASE, REG_NONE
   } cal_reg_t;

endpackage : cal_pkg

`default_nettype wire

// ===== common/cal_if.sv
// Link between the register core and the seconds tick generator
`timescale 1ns/100ps
`default_nettype none

interface cal_if;
   logic        run;
   logic [15:0] period;
   logic        tick;
   logic [15:0] base;

   modport gen  (input run, input period, output tick, output base);
   modport core (output run, output period, input tick, input base);
endinterface : cal_if

`default_nettype wire

// ===== src/cal_tick_gen.sv
// Base counter and calibrated seconds tick generator
`timescale 1ns/100ps
`default_nettype none

module cal_tick_gen
   import cal_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_osc_tick,
   cal_if.gen        tk
);

   logic [15:0] base_q;
   logic        tick_q;
   logic        at_end;

   assign at_end = (base_q >= tk.period);

   // Held at zero while stopped so the first second after start is whole
   always_ff @(posedge i_clk) begin
      if (i_rst || !tk.run) begin
         base_q <= BASE_RST;
      end else if (i_osc_tick) begin
         base_q <= at_end ? BASE_RST : base_q + 16'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tk.run & i_osc_tick & at_end;
      end
   end

   assign tk.tick = tick_q;
   assign tk.base = base_q;

endmodule : cal_tick_gen

`default_nettype wire

// ===== testbench/cal_rtc_top_monitor.sv
// Checker for bus handshakes and interrupt outputs of the calendar clock
`timescale 1ns/100ps
`default_nettype none

module cal_rtc_top_monitor (
   input wire logic        I_CORE_CLK,
   input wire logic        I_SYS_RST,
   input wire logic        I_OSC_TICK,
   input wire logic        I_S_AXI_AWVALID,
   input wire logic        O_S_AXI_AWREADY,
   input wire logic        I_S_AXI_WVALID,
   input wire logic        O_S_AXI_WREADY,
   input wire logic [1:0]  O_S_AXI_BRESP,
   input wire logic        O_S_AXI_BVALID,
   input wire logic        I_S_AXI_BREADY,
   input wire logic        I_S_AXI_ARVALID,
   input wire logic        O_S_AXI_ARREADY,
   input wire logic [31:0] O_S_AXI_RDATA,
   input wire logic        O_S_AXI_RVALID,
   input wire logic        I_S_AXI_RREADY,
   input wire logic        O_IRQ,
   input wire logic        O_WAKE
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);

   // Age of the last possible cause of an interrupt; saturates
   logic [3:0] age_q;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || I_OSC_TICK || I_S_AXI_WVALID) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
   end

   property p_wake_irq;
      O_WAKE == O_IRQ;
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("wake differs from irq");
   property p_irq_cause;
      $rose(O_IRQ) |-> age_q < 4'h8;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
   property p_reset_quiet;
      $fell(I_SYS_RST) |-> !O_IRQ && !O_S_AXI_BVALID && !O_S_AXI_RVALID;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
   property p_b_hold;
      O_S_AXI_BVALID && !I_S_AXI_BREADY |=> O_S_AXI_BVALID && $stable(O_S_AXI_BRESP);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      O_S_AXI_RVALID && !I_S_AXI_RREADY |=> O_S_AXI_RVALID && $stable(O_S_AXI_RDATA);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_ready;
      O_S_AXI_ARREADY == !O_S_AXI_RVALID;
   endproperty
   a_ar_ready: assert property (p_ar_ready) else $error("arready wrong");
   property p_r_answer;
      I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("no read answer");
   property p_b_answer;
      I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID && O_S_AXI_WREADY
         |-> ##[1:3] O_S_AXI_BVALID;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("no write answer");
   property p_aw_busy;
      I_S_AXI_AWVALID && O_S_AXI_AWREADY |=> !O_S_AXI_AWREADY;
   endproperty
   a_aw_busy: assert property (p_aw_busy) else $error("awready stayed high");
endmodule : cal_rtc_top_monitor

bind cal_rtc_top cal_rtc_top_monitor u_mon (
   .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_OSC_TICK(I_OSC_TICK),
   .I_S_AXI_AWVALID(I_S_AXI_AWVALID), .O_S_AXI_AWREADY(O_S_AXI_AWREADY),
   .I_S_AXI_WVALID(I_S_AXI_WVALID), .O_S_AXI_WREADY(O_S_AXI_WREADY),
   .O_S_AXI_BRESP(O_S_AXI_BRESP), .O_S_AXI_BVALID(O_S_AXI_BVALID),
   .I_S_AXI_BREADY(I_S_AXI_BREADY), .I_S_AXI_ARVALID(I_S_AXI_ARVALID),
   .O_S_AXI_ARREADY(O_S_AXI_ARREADY), .O_S_AXI_RDATA(O_S_AXI_RDATA),
   .O_S_AXI_RVALID(O_S_AXI_RVALID), .I_S_AXI_RREADY(I_S_AXI_RREADY),
   .O_IRQ(O_IRQ), .O_WAKE(O_WAKE)
);

`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the calendar clock counters
`timescale 1ns/100ps
`default_nettype none

module tb
   import cal_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              osc = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic [31:0]       wdata = 32'h0000_0000;
   logic              awv = 1'b0;
   logic              wv = 1'b0;
   logic              bready = 1'b0;
   logic              arv = 1'b0;
   logic              rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid, irq, wake;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   int                n_mismatch = 0;
   int                comparisons = 0;

   // Bytes 0..7 are second..century; load value above, value one second later below
   localparam logic [127:0] ROWS [10] = '{
      128'h0000_0103_0A05_1E0A_0000_0103_0A05_1E0B,
      128'h0063_0C06_1F17_3B3B_0100_0100_0100_0000,
      128'h0001_0202_1C17_3B3B_0001_0303_0100_0000,
      128'h0004_0202_1C17_3B3B_0004_0203_1D00_0000,
      128'h0100_0202_1C17_3B3B_0100_0303_0100_0000,
      128'h0400_0202_1C17_3B3B_0400_0203_1D00_0000,
      128'h0005_0401_1E17_3B3B_0005_0502_0100_0000,
      128'h0005_0101_1E17_3B3B_0005_0102_1F00_0000,
      128'h0763_0C06_1F17_3B3B_0000_0100_0100_0000,
      128'h0000_0100_010C_3B3B_0000_0100_010D_0000};
   localparam logic [63:0]  RST_T = 64'h0000_0100_0100_0000;

   always #4 clk = ~clk;

   cal_rtc_top dut (
      .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_OSC_TICK(osc),
      .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awready),
      .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(4'hF), .I_S_AXI_WVALID(wv),
      .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid),
      .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arv),
      .O_S_AXI_ARREADY(arready), .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp),
      .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready), .O_IRQ(irq), .O_WAKE(wake));

   // ------------
   // Checks and bus tasks
   // ------------
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t data %h expected %h", $time, got, exp);
      end
   endtask : chk_data

   task automatic chk_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_flag

   task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
      int t;
      @(posedge clk);
      awaddr <= ADDR_W'({idx, 2'b00});
      wdata <= {24'h00_0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         // Ready comes late on purpose so the slave must hold its answer
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready) && t < 50);
      chk_flag(bvalid, 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      int t;
      @(posedge clk);
      araddr <= ADDR_W'({idx, 2'b00});
      arv <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
         if (arready) arv <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready) && t < 50);
      chk_flag(rvalid, 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(idx, d, r);
      chk_data({30'h0, r}, {30'h0, RESP_OKAY});
   endtask : wr

   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(idx, d, r);
      chk_data(d, {24'h00_0000, e});
      chk_data({30'h0, r}, {30'h0, RESP_OKAY});
   endtask : rd_chk

   // Stopping first also clears the counters, so loads never race a tick
   task automatic load(input logic [63:0] v);
      wr(IDX_CTRL, 8'h00);
      for (int i = 0; i < 8; i++) wr(IDX_SEC + 16'(i), v[8*i +: 8]);
   endtask : load

   task automatic check_time(input logic [63:0] e);
      for (int i = 0; i < 8; i++) rd_chk(IDX_SEC + 16'(i), e[8*i +: 8]);
   endtask : check_time

   // One oscillator pulse gives exactly one second when the calibration is zero
   task automatic pulse();
      @(posedge clk);
      osc <= 1'b1;
      @(posedge clk);
      osc <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulse

   task automatic end_of_test();
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // ------------
   // Main sequence
   // ------------
   initial begin
      logic [7:0]  c;
      logic [31:0] d;
      logic [1:0]  r;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      check_time(RST_T);
      rd_chk(IDX_CTRL, 8'h00);
      wr(IDX_CALIB, 8'h00);
      for (int i = 0; i < 10; i++) begin
         load(ROWS[i][127:64]);
         wr(IDX_CTRL, 8'h80);
         pulse();
         check_time(ROWS[i][63:0]);
         rd_chk(IDX_CTRL, 8'hE0);
         chk_flag(irq, 1'b0);
      end
      wr(IDX_SEC, 8'h05);
      rd_chk(IDX_SEC, 8'h00);
      wr(IDX_CTRL, 8'h00);
      check_time(RST_T);
      wr(IDX_HOUR, 8'hFF);
      rd_chk(IDX_HOUR, 8'h1F);
      // Pass 4 repeats the day period with an hour carry, which must fire
      for (int s = 0; s < 5; s++) begin
         c = {4'h9, 2'((s == 4) ? 3 : s), 2'b00};
         load({40'h00_0001_0001, (s == 4) ? 8'h17 : 8'h16, 16'h3B3B});
         wr(IDX_CTRL, c);
         pulse();
         rd_chk(IDX_CTRL, c | {2'b01, s != 3, 5'h00});
         chk_flag(irq, s != 3);
         chk_flag(wake, s != 3);
         wr(IDX_CTRL, c);
         chk_flag(irq, 1'b0);
         check_time((s == 4) ? 64'h0000_0101_0200_0000 : 64'h0000_0100_0117_0000);
         rd_chk(IDX_CTRL, c);
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd_chk(IDX_CTRL, 8'h00);
      check_time(RST_T);
      axi_wr(16'h7EFF, 8'h12, r);
      chk_data({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_rd(16'h7EFF, d, r);
      chk_data(d, 32'h0000_0000);
      chk_data({30'h0, r}, {30'h0, RESP_SLVERR});
      end_of_test();
   end

   // The full sequence needs under two thousand cycles; this leaves wide margin
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
endmodule : tb

`default_nettype wire
